//--- design/cmd_step_match.sv
// one step of the unlock sequence: compares a bus write against its expected pattern
`timescale 1ns/1ps
module cmd_step_match #(
    parameter logic [7:0] ADDR_BYTE = 8'h55,
    parameter logic [7:0] DATA_BYTE = 8'haa
) (
    // bus write seen this cycle
    input wire logic [7:0] addr_hi,
    input wire logic [7:0] wdata,
    // compare result
    output logic hit
);
    // address byte 15:8 and data must both match
    assign hit = (addr_hi == ADDR_BYTE) && (wdata == DATA_BYTE);
endmodule // cmd_step_match

//--- design/flash_protect_erase_status.sv
// protection-flag erase sequencer and flash status register
`timescale 1ns/1ps
`include "flash_protect_map.svh"
module flash_protect_erase_status #(
    parameter int ERASE_CYCLES = `ERASE_CYCLES,
    parameter int BLOCKS = 4
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // cpu bus cycles
    input wire flash_protect_pkg::flash_bus_req_t bus_req,
    output logic [31:0] rdata,
    // flash array side
    input wire logic rom_kind_in,
    input wire logic erase_fail,
    input wire logic [3:0] prot_init,
    input wire logic prot_init_load,
    // busy flag to decoder and read-mode controller
    output logic busy
);
    import flash_protect_pkg::*;

    // elaboration check: the flag logic is written for exactly four blocks,
    // and a zero-length erase would never reach its end count
    if (BLOCKS != 4 || ERASE_CYCLES < 1) begin : g_param_check
        $error("unsupported parameter values");
    end

    localparam logic [7:0] CMD_A = `CMD_UNLOCK_A;
    localparam logic [7:0] CMD_B = `CMD_UNLOCK_B;
    localparam logic [7:0] CMD_E = `CMD_PROT_ERASE;
    localparam logic [7:0] AD_A = `ADDR_UNLOCK_A;
    localparam logic [7:0] AD_B = `ADDR_UNLOCK_B;

    // registers
    seq_state_t state_reg, state_next;
    logic [2:0] step_reg, step_next; // writes matched so far
    logic [3:0] prot_reg, prot_next; // block protection flags
    logic [3:0] pair_reg, pair_next; // pair selected for erase
    logic [31:0] cnt_reg, cnt_next; // erase duration counter
    logic rom_reg; // rom kind captured after reset
    logic rom_done_reg; // capture done marker
    logic [31:0] rdata_reg; // status word returned to the cpu

    // step pattern hits
    logic hit_a; // first unlock pattern
    logic hit_b; // second unlock pattern
    logic hit_e1; // erase code at the unlock address
    logic hit_e2; // erase code at any address
    // only address byte 15:8 takes part in the unlock compare
    wire [7:0] ahi = bus_req.addr[15:8];
    wire [7:0] wd = bus_req.wdata;

    // first and fourth writes
    cmd_step_match #(
        .ADDR_BYTE(AD_A),
        .DATA_BYTE(CMD_A)
    ) u_a (
        .addr_hi(ahi),
        .wdata(wd),
        .hit(hit_a)
    );

    // second and fifth writes
    cmd_step_match #(
        .ADDR_BYTE(AD_B),
        .DATA_BYTE(CMD_B)
    ) u_b (
        .addr_hi(ahi),
        .wdata(wd),
        .hit(hit_b)
    );

    // third and sixth writes
    cmd_step_match #(
        .ADDR_BYTE(AD_A),
        .DATA_BYTE(CMD_E)
    ) u_e (
        .addr_hi(ahi),
        .wdata(wd),
        .hit(hit_e1)
    );

    // seventh write: the address carries the pair, so only the data counts
    assign hit_e2 = (wd == CMD_E);

    // expected pattern for the current step (steps 0..5), seventh is any address
    wire step_ok = (step_reg == 3'd0 || step_reg == 3'd3) ? hit_a :
                   (step_reg == 3'd1 || step_reg == 3'd4) ? hit_b :
                   (step_reg == 3'd2 || step_reg == 3'd5) ? hit_e1 : hit_e2;
    // read mode is the only state that takes command writes; status reads are answered in every state
    wire in_read = (state_reg == ST_READ);
    // command writes count only in read mode, so a busy flash drops them silently
    wire cmd_wr = bus_req.wr && in_read;
    // the write that completes the sequence
    wire last_wr = cmd_wr && step_ok && (step_reg == (`SEQ_LEN - 3'd1));
    // seventh write address bit 0 picks the pair: 0 -> flags 1:0, 1 -> flags 3:2;
    // a single flag or all four can never be selected
    wire [3:0] sel_pair = bus_req.addr[0] ? 4'hc : 4'h3;
    // with every flag set the command belongs to the whole-array path, not here
    wire all_prot = (prot_reg == 4'hf);
    // last cycle of the erase time
    wire cnt_end = (cnt_reg == 32'(ERASE_CYCLES - 1));

    // next state logic
    always_comb begin
        state_next = state_reg;
        step_next = step_reg;
        prot_next = prot_reg;
        pair_next = pair_reg;
        cnt_next = cnt_reg;
        unique case (state_reg)
            // read mode: follow the command sequence
            ST_READ: begin
                // stand-in for the protection programming path
                if (prot_init_load) begin
                    prot_next = prot_init;
                end
                if (cmd_wr) begin
                    if (last_wr) begin
                        step_next = 3'd0;
                        // all-protected path is handled elsewhere
                        if (!all_prot) begin
                            state_next = ST_ERASE;
                            pair_next = sel_pair;
                            cnt_next = 32'h0;
                        end
                    end else if (step_ok) begin
                        // expected write: advance one step
                        step_next = step_reg + 3'd1;
                    end else begin
                        // wrong write: start the sequence again
                        step_next = 3'd0;
                    end
                end
            end
            // erase running: bus writes are not looked at here
            ST_ERASE: begin
                // no command can stop this; only rstn or erase_fail does
                if (erase_fail) begin
                    // a failure wins over the end count
                    state_next = ST_FAIL;
                end else if (cnt_end) begin
                    prot_next = prot_reg & ~pair_reg;
                    state_next = ST_READ;
                end else begin
                    // erase still running
                    cnt_next = cnt_reg + 32'h1;
                end
            end
            // failed erase: locked until hardware reset
            ST_FAIL: begin
                state_next = ST_FAIL;
            end
            // unused code: fall back to read mode
            default: begin
                state_next = ST_READ;
            end
        endcase
    end

    // state registers, all cleared by hardware reset; this is also the only
    // way out of a failed erase and, besides erase_fail, the only way to stop a running one
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_READ;
            step_reg <= 3'd0;
            prot_reg <= 4'h0;
            pair_reg <= 4'h0;
            cnt_reg <= 32'h0;
        end else begin
            state_reg <= state_next;
            step_reg <= step_next;
            prot_reg <= prot_next;
            pair_reg <= pair_next;
            cnt_reg <= cnt_next;
        end
    end

    // rom kind captured on the first clock after reset release
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rom_reg <= 1'b0;
            rom_done_reg <= 1'b0;
        end else if (!rom_done_reg) begin
            rom_reg <= rom_kind_in;
            rom_done_reg <= 1'b1;
        end
    end

    // status word fields; ready flag high only in read mode
    wire ready_busy_flag = in_read;
    wire rom_kind_bit = rom_reg;
    wire [3:0] block_protect_flags = prot_reg;
    // bits 31:8, 3 and 1 are tied to zero
    wire [31:0] status_word = {24'h0, block_protect_flags, 1'b0, rom_kind_bit,
                               1'b0, ready_busy_flag};
    // a read cycle at the status address
    wire status_hit = bus_req.rd && (bus_req.addr == `FLASH_STATUS_ADDR);

    // read data register; writes to the status address do nothing
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= 32'h0;
        end else if (status_hit) begin
            rdata_reg <= status_word;
        end
    end

    // outputs: data from the register, busy straight from the state
    assign rdata = rdata_reg;
    // tells the decoder and the read-mode controller that an erase owns the array
    assign busy = !in_read;
endmodule // flash_protect_erase_status

//--- design/flash_protect_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef FLASH_PROTECT_MAP_SVH
`define FLASH_PROTECT_MAP_SVH
`define FLASH_STATUS_ADDR 32'hffffe520
`define FS_RDY_BIT 0
`define FS_ROM_BIT 2
`define FS_PROT_LSB 4
`define FS_PROT_MSB 7
`define FS_RESET_VALUE 32'h00000001
`define CMD_UNLOCK_A 8'haa
`define CMD_UNLOCK_B 8'h55
`define CMD_PROT_ERASE 8'h6a
`define ADDR_UNLOCK_A 8'h55
`define ADDR_UNLOCK_B 8'haa
`define SEQ_LEN 3'd7
`define ERASE_TIME_US 10
`define CLK_MHZ 25
`define ERASE_CYCLES (`ERASE_TIME_US * `CLK_MHZ)
`endif

//--- design/flash_protect_pkg.sv
// types shared by the protection-erase sequencer
package flash_protect_pkg;
    // cpu bus write or read cycle toward the flash
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } flash_bus_req_t;
    // sequencer states
    typedef enum logic [1:0] {
        ST_READ  = 2'b00,
        ST_ERASE = 2'b01,
        ST_FAIL  = 2'b10
    } seq_state_t;
endpackage

//--- dv/cpu_bus_model.sv
// cpu model issuing flash command writes and status reads
`timescale 1ns/1ps
module cpu_bus_model (
    // clock and status data
    input wire logic clk_sys,
    input wire logic [31:0] rdata,
    // bus cycles
    output flash_protect_pkg::flash_bus_req_t bus_req
);
    import flash_protect_pkg::*;
    initial bus_req = '0;
    // one write pulse; released lines show inverted values
    task automatic wr(input logic [31:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        bus_req = '{1'b1, 1'b0, a, d};
        @(negedge clk_sys);
        bus_req = '{1'b0, 1'b0, ~a, ~d};
    endtask
    // status read, data taken one cycle after the strobe
    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(negedge clk_sys);
        bus_req = '{1'b0, 1'b1, a, 8'h0};
        @(negedge clk_sys);
        bus_req = '{1'b0, 1'b0, ~a, 8'hff};
        v = rdata;
    endtask
    // seven-write erase command, no abort command exists here; p picks the pair
    task automatic seq(input logic p);
        logic [7:0] ab[6] = '{8'h55, 8'haa, 8'h55, 8'h55, 8'haa, 8'h55};
        logic [7:0] db[6] = '{8'haa, 8'h55, 8'h6a, 8'haa, 8'h55, 8'h6a};
        for (int i = 0; i < 6; i++) begin
            wr({16'h0, ab[i], 8'h0}, db[i]);
        end
        wr({31'h0, p}, 8'h6a);
    endtask
endmodule // cpu_bus_model

//--- dv/flash_protect_erase_status_tb.sv
// self-checking bench for the protection-erase sequencer
`timescale 1ns/1ps
`include "flash_protect_map.svh"
module flash_protect_erase_status_tb;
    import flash_protect_pkg::*;
    localparam int EC = 40;
    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    logic rom_kind_in = 1'b1;
    logic erase_fail = 1'b0;
    logic [3:0] prot_init = 4'h0;
    logic prot_init_load = 1'b0;
    flash_bus_req_t bus_req;
    logic [31:0] rdata;
    logic busy;
    int errors = 0;
    int checks = 0;
    always #20 clk_sys = ~clk_sys;
    flash_protect_erase_status #(.ERASE_CYCLES(EC)) flash_protect_erase_status_inst (
        .clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req), .rdata(rdata),
        .rom_kind_in(rom_kind_in), .erase_fail(erase_fail), .prot_init(prot_init),
        .prot_init_load(prot_init_load), .busy(busy));
    cpu_bus_model cpu_bus_model_inst (.clk_sys(clk_sys), .rdata(rdata), .bus_req(bus_req));
    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // read the status register and compare
    task automatic st(input logic [31:0] exp);
        logic [31:0] v;
        cpu_bus_model_inst.rd(`FLASH_STATUS_ADDR, v);
        chk(v, exp);
    endtask
    task automatic conclude();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic do_reset();
        rstn = 1'b0;
        repeat (10) @(negedge clk_sys);
        rstn = 1'b1;
        repeat (2) @(negedge clk_sys);
    endtask
    // reset value, write to status ignored, flag load
    task automatic t_status();
        st(32'h05);
        cpu_bus_model_inst.wr(`FLASH_STATUS_ADDR, 8'hff);
        st(32'h05);
        @(negedge clk_sys) {prot_init, prot_init_load} = {4'hb, 1'b1};
        @(negedge clk_sys) prot_init_load = 1'b0;
        st(32'hb5);
        $display("status test done");
    endtask
    // low pair erase with a command ignored mid-run, then high pair
    task automatic t_erase();
        cpu_bus_model_inst.seq(1'b0);
        chk({31'h0, busy}, 32'h1);
        st(32'hb4);
        cpu_bus_model_inst.seq(1'b1);
        repeat (EC) @(negedge clk_sys);
        st(32'h85);
        chk({31'h0, busy}, 32'h0);
        cpu_bus_model_inst.seq(1'b1);
        repeat (EC + 5) @(negedge clk_sys);
        st(32'h05);
        $display("erase test done");
    endtask
    // failed erase holds busy until a hardware reset
    task automatic t_fail();
        @(negedge clk_sys) {prot_init, prot_init_load} = {4'h3, 1'b1};
        @(negedge clk_sys) prot_init_load = 1'b0;
        cpu_bus_model_inst.seq(1'b0);
        erase_fail = 1'b1;
        repeat (EC + 10) @(negedge clk_sys);
        st(32'h34);
        chk({31'h0, busy}, 32'h1);
        {rom_kind_in, erase_fail} = 2'b00;
        do_reset();
        st(32'h01);
        chk({31'h0, busy}, 32'h0);
        $display("fail test done");
    endtask
    initial begin
        do_reset();
        t_status();
        t_erase();
        t_fail();
        conclude();
    end
    // watchdog: the tests need a few hundred cycles, so this span is ample
    initial begin
        repeat (30 * (EC + 10)) @(negedge clk_sys);
        errors++;
        conclude();
    end
endmodule // flash_protect_erase_status_tb
bind flash_protect_erase_status flash_protect_monitor #(.ERASE_CYCLES(ERASE_CYCLES))
    flash_protect_monitor_inst (.clk_sys(clk_sys), .rstn(rstn), .bus_req(bus_req),
    .rdata(rdata), .erase_fail(erase_fail), .busy(busy));

//--- dv/flash_protect_monitor.sv
// checker for the protection-erase sequencer ports
`timescale 1ns/1ps
`include "flash_protect_map.svh"
module flash_protect_monitor #(parameter int ERASE_CYCLES = `ERASE_CYCLES) (
    // watched ports
    input wire logic clk_sys,
    input wire logic rstn,
    input wire flash_protect_pkg::flash_bus_req_t bus_req,
    input wire logic [31:0] rdata,
    input wire logic erase_fail,
    input wire logic busy
);
    import flash_protect_pkg::*;
    localparam int LIM = ERASE_CYCLES + 2;
    // status read request seen
    wire logic rd_hit = bus_req.rd && bus_req.addr == `FLASH_STATUS_ADDR;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_ready_mirror: assert property (rd_hit |=> rdata[0] == !$past(busy))
        else $error("ready flag wrong");
    chk_zero_bits: assert property (rdata[31:8] == 24'h0 && !rdata[3] && !rdata[1])
        else $error("reserved bit set");
    chk_start_write: assert property ($rose(busy) |-> $past(bus_req.wr))
        else $error("erase began without write");
    chk_fail_hold: assert property (busy && erase_fail |=> busy[*8])
        else $error("busy left after failure");
    chk_rdata_hold: assert property (!rd_hit |=> $stable(rdata))
        else $error("status data moved");
    chk_erase_ends: assert property ($rose(busy) && !erase_fail
        |-> ##[1:LIM] (!busy || erase_fail))
        else $error("erase too long");
    chk_no_restart: assert property ($fell(busy) |-> !busy[*7])
        else $error("erase restarted early");
    chk_reset_ready: assert property ($rose(rstn) |-> !busy)
        else $error("busy after reset");
endmodule // flash_protect_monitor
